/* design/spi_flc_pkg.sv */
// Shared constants, types and CRC function for the frame-length checker link
package spi_flc_pkg;

    // Frame lengths in serial clock pulses
    localparam int FRAME16 = 16;
    localparam int FRAME17 = 17;
    localparam int FRAME20 = 20;
    localparam int FRAME21 = 21;
    localparam int CNT_W   = 5;
    localparam int CMD_W   = 16;
    localparam int CRC_W   = 4;

    // Nonvolatile seventeen-clock select location
    localparam logic [7:0] NV_S17_LOC = 8'h1b;
    localparam int         NV_S17_BIT = 1;
    localparam logic       S17_RESET  = 1'b0;

    // Serial register map
    localparam logic [5:0] NOP_ADDR       = 6'h00;
    localparam logic [5:0] WARN_ADDR      = 6'h26;
    localparam int         WARN_FRAME_BIT = 11;
    localparam int         WARN_CRC_BIT   = 10;
    localparam logic [3:0] WARN_FIXED     = 4'hb;
    localparam int         REG_WORDS      = 32;

    // Timing
    localparam int CLK_NS    = 50;
    localparam int GUARD_NS  = 70;
    localparam int GUARD_CYC = (GUARD_NS / CLK_NS < 1) ? 1 : GUARD_NS / CLK_NS;

    // CRC polynomial x^4+x+1 and seed
    localparam logic [3:0] CRC_POLY = 4'h3;
    localparam logic [3:0] CRC_SEED = 4'hf;

    typedef enum logic [1:0] {
        LEN16 = 2'b00,
        LEN17 = 2'b01,
        LEN20 = 2'b10,
        LEN21 = 2'b11
    } frame_len_e;

    function automatic logic [3:0] crc4(input logic [15:0] d);
        logic [3:0] c;
        logic       fb;
        c = CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            fb = c[3] ^ d[i];
            c  = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
        end
        return c;
    endfunction : crc4

endpackage : spi_flc_pkg

/* design/spi_link_if.sv */
// Serial link between host master and checking device
`timescale 1ns/1ps
interface spi_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;

    // Shared data line pulled low when undriven
    assign miso = miso_oe & miso_o;

    modport dev (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : spi_link_if

/* design/spi_frame_dev.sv */
// Device end: frame edge counting, frame error flags, register access
//
// Behaviour
// - Short modes count stray falling edges too
// - 16-bit, select clear: one stray flags
// - Seventeen-clock select at 0x1B bit 1, default 0
// - 16-bit, select set: two strays flag
// - 17-bit, select set: one stray flags
// - Early stray edge may drop the read
// - Late stray in 16/17 corrupts next response
// - Late stray in 20-bit keeps responses intact
// - Write dropped if early, flagged if late
// - 20-bit false flags stay rare
// - After 21-bit frame ignore idle edges
// - Master sends 16, 17, 20 or 21 clocks per request
// - Master MOSI: sync, rw, addr, data, crc, zero
// - MISO: 16 data, 4 CRC, CRC MSB again
// - Master ignores the repeated CRC bit
// - Idle devices flag first bus frame after power-up
// - Power-on error also sets CRC flag
// - Master clears flags after power-on
// - Dedicated clock held high outside frames
// - Address 0x0 reads all zeros
// - Master prefers 21-bit frames on shared lines
// - Frame flag is warning bit 11, read-only
// - Sync bit of one flags frame error
`timescale 1ns/1ps
module spi_frame_dev
    import spi_flc_pkg::*;
(
    // System clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Serial link, clocked by its own sclk
    spi_link_if.dev         link,
    // Nonvolatile programming and options
    input  wire logic       nv_we,
    input  wire logic [7:0] nv_addr,
    input  wire logic [7:0] nv_wdata,
    input  wire logic       crc_check_en,
    // Status
    output logic            frame_error_flag,
    output logic            crc_error_flag,
    output logic            seventeen_clock_select,
    // Register write report
    output logic            wr_pulse,
    output logic [5:0]      wr_addr,
    output logic [7:0]      wr_data
);

    typedef enum logic [1:0] {
        G_IDLE   = 2'b00,
        G_WAIT   = 2'b01,
        G_COMMIT = 2'b10
    } guard_e;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction : sat_inc

    function automatic logic cnt_ok(input logic [CNT_W-1:0] c, input logic s17);
        return (c == CNT_W'(FRAME16)) || (s17 && c == CNT_W'(FRAME17)) ||
               (c == CNT_W'(FRAME20)) || (c == CNT_W'(FRAME21));
    endfunction : cnt_ok

    // Link domain state
    logic               newf_q;
    logic [CNT_W-1:0]   stray_q;
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   bits_q;
    logic [FRAME21-1:0] rx_q;
    logic [FRAME21-1:0] tx_q;
    logic               mode21_q;
    logic               stray_tgl_q;

    // System domain state
    logic [FRAME21-1:0] resp_q;
    logic [2:0]         cs_s_q;
    logic               cs_f_q;
    logic [2:0]         st_s_q;
    logic               st_f_q;
    guard_e             g_state_q;
    logic [3:0]         g_cnt_q;
    logic               drop_q;
    logic               s17_q;
    logic               fe_q;
    logic               ce_q;
    logic [15:0]        regs_q [REG_WORDS];

    // Async set by chip select, so the first edge of a frame is always known
    always_ff @(negedge link.sclk or posedge rst or posedge link.cs_n) begin
        if (rst) begin
            newf_q <= 1'b1;
        end else if (link.cs_n) begin
            newf_q <= 1'b1;
        end else begin
            newf_q <= 1'b0;
        end
    end

    // Stray edges while deselected; ignored while the last frame was 21 bits
    always_ff @(negedge link.sclk or posedge rst) begin
        if (rst) begin
            stray_q     <= '0;
            stray_tgl_q <= 1'b0;
        end else if (link.cs_n && !mode21_q) begin
            stray_q     <= sat_inc(stray_q);
            stray_tgl_q <= ~stray_tgl_q;
        end else if (!link.cs_n && newf_q) begin
            stray_q     <= '0;
        end
    end

    // Edge count includes strays; bits counts only shifted bits
    always_ff @(negedge link.sclk or posedge rst) begin
        if (rst) begin
            cnt_q  <= '0;
            bits_q <= '0;
        end else if (!link.cs_n) begin
            cnt_q  <= newf_q ? sat_inc(stray_q) : sat_inc(cnt_q);
            bits_q <= newf_q ? CNT_W'(1) : sat_inc(bits_q);
        end
    end

    always_ff @(negedge link.sclk or posedge rst) begin
        if (rst) begin
            mode21_q <= 1'b0;
        end else if (!link.cs_n) begin
            mode21_q <= !newf_q && (bits_q == CNT_W'(FRAME21 - 1));
        end
    end

    always_ff @(negedge link.sclk or posedge rst) begin
        if (rst) begin
            rx_q <= '0;
            tx_q <= '0;
        end else if (!link.cs_n) begin
            rx_q <= {rx_q[FRAME21-2:0], link.mosi};
            tx_q <= newf_q ? resp_q : {tx_q[FRAME21-2:0], 1'b0};
        end
    end

    assign link.miso_o  = newf_q ? resp_q[FRAME21-1] : tx_q[FRAME21-1];
    assign link.miso_oe = !link.cs_n;

    // Chip select and stray-edge toggle into the system domain
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_s_q <= 3'h7;
            cs_f_q <= 1'b1;
            st_s_q <= 3'h0;
            st_f_q <= 1'b0;
        end else begin
            cs_s_q <= {cs_s_q[1:0], link.cs_n};
            st_s_q <= {st_s_q[1:0], stray_tgl_q};
            if (cs_s_q[1] == cs_s_q[2]) begin
                cs_f_q <= cs_s_q[2];
            end
            if (st_s_q[1] == st_s_q[2]) begin
                st_f_q <= st_s_q[2];
            end
        end
    end

    logic cs_rise;
    logic stray_evt;
    assign cs_rise   = (cs_s_q[1] == cs_s_q[2]) && cs_s_q[2] && !cs_f_q;
    assign stray_evt = (st_s_q[1] == st_s_q[2]) && (st_s_q[2] != st_f_q);

    // Frame held back for the guard time; a stray edge inside it drops it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            g_state_q <= G_IDLE;
            g_cnt_q   <= '0;
            drop_q    <= 1'b0;
        end else begin
            case (g_state_q)
                G_IDLE: begin
                    if (cs_rise) begin
                        g_state_q <= G_WAIT;
                        g_cnt_q   <= 4'(GUARD_CYC);
                        drop_q    <= stray_evt;
                    end
                end
                G_WAIT: begin
                    drop_q <= drop_q | stray_evt;
                    if (g_cnt_q <= 4'h1) begin
                        g_state_q <= G_COMMIT;
                    end
                    g_cnt_q <= g_cnt_q - 4'h1;
                end
                G_COMMIT: g_state_q <= G_IDLE;
                default:  g_state_q <= G_IDLE;
            endcase
        end
    end

    // Frame decode; shift and count registers are quiet while select is high
    logic [CNT_W-1:0] src;
    logic [2:0]       off;
    logic [15:0]      cmd;
    logic [3:0]       crc_rx;
    logic             has_crc;
    always_comb begin
        // Long frames align on real bits; short ones on the raw edge count
        src = (bits_q >= CNT_W'(FRAME20)) ? bits_q : cnt_q;
        if (src < CNT_W'(FRAME16)) begin
            off = 3'h0;
        end else if (src > CNT_W'(FRAME21)) begin
            off = 3'h5;
        end else begin
            off = 3'(src - CNT_W'(FRAME16));
        end
        cmd     = 16'(rx_q >> off);
        has_crc = off >= 3'h4;
        crc_rx  = has_crc ? 4'(rx_q >> (off - 3'h4)) : 4'h0;
    end

    logic        commit;
    logic        rw;
    logic [5:0]  addr;
    logic        is_warn;
    logic        fe_set;
    logic        ce_set;
    logic        flag_clr;
    logic [15:0] rd_word;
    assign commit   = (g_state_q == G_COMMIT) && !drop_q;
    assign rw       = cmd[14];
    assign addr     = cmd[13:8];
    assign is_warn  = addr[5:1] == WARN_ADDR[5:1];
    assign fe_set   = commit && (!cnt_ok(cnt_q, s17_q) || cmd[15]);
    assign ce_set   = commit && crc_check_en &&
                      (fe_set || (has_crc && crc_rx != crc4(cmd)));
    assign flag_clr = commit && rw && is_warn;

    always_comb begin
        rd_word = regs_q[addr[5:1]];
        if (addr[5:1] == NOP_ADDR[5:1]) begin
            rd_word = 16'h0000;
        end else if (is_warn) begin
            rd_word = {WARN_FIXED, fe_q, ce_q, 10'h000};
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fe_q <= 1'b0;
            ce_q <= 1'b0;
        end else begin
            fe_q <= fe_set | (fe_q & ~flag_clr);
            ce_q <= ce_set | (ce_q & ~flag_clr);
        end
    end

    // Idle answer carries a true CRC, so the first answer after reset checks clean
    localparam logic [3:0] IDLE_CRC = crc4(16'h0000);
    logic [3:0]            rd_crc;
    assign rd_crc = crc4(rd_word);

    // Read answer is shifted out during the next frame
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resp_q <= {16'h0000, IDLE_CRC, IDLE_CRC[3]};
        end else if (commit && !rw) begin
            resp_q <= {rd_word, rd_crc, rd_crc[3]};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_WORDS; i++) begin
                regs_q[i] <= '0;
            end
            wr_pulse <= 1'b0;
            wr_addr  <= '0;
            wr_data  <= '0;
        end else begin
            wr_pulse <= 1'b0;
            if (commit && rw && !is_warn && addr[5:1] != NOP_ADDR[5:1]) begin
                // Even address is the high byte
                if (addr[0]) begin
                    regs_q[addr[5:1]][7:0] <= cmd[7:0];
                end else begin
                    regs_q[addr[5:1]][15:8] <= cmd[7:0];
                end
                wr_pulse <= 1'b1;
                wr_addr  <= addr;
                wr_data  <= cmd[7:0];
            end
        end
    end

    // Reset stands in for the factory default of the stored bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s17_q <= S17_RESET;
        end else if (nv_we && nv_addr == NV_S17_LOC) begin
            s17_q <= nv_wdata[NV_S17_BIT];
        end
    end

    assign frame_error_flag       = fe_q;
    assign crc_error_flag         = ce_q;
    assign seventeen_clock_select = s17_q;

endmodule : spi_frame_dev

/* design/spi_frame_host.sv */
// Host end: serial master with divided clock and power-on flag clear
`timescale 1ns/1ps
module spi_frame_host
    import spi_flc_pkg::*;
#(
    parameter int HALF = 4,
    parameter int GAP  = 16
) (
    // System clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Serial link, this end makes the clock
    spi_link_if.host         link,
    // Request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [5:0]  req_addr,
    input  wire logic [7:0]  req_data,
    input  wire logic [1:0]  req_len,
    // Response of the frame just ended
    output logic             resp_valid,
    output logic [15:0]      resp_data,
    output logic             resp_crc_ok,
    output logic             init_done
);

    if (HALF < 4 || HALF > 255 || GAP < 12 || GAP > 255) begin : g_bad_param
        $error("HALF must be 4..255 and GAP 12..255");
    end

    typedef enum logic [2:0] {
        H_INIT  = 3'b000,
        H_IDLE  = 3'b001,
        H_SETUP = 3'b010,
        H_LOW   = 3'b011,
        H_HIGH  = 3'b100,
        H_GAP   = 3'b101
    } host_e;

    function automatic logic [CNT_W-1:0] len_bits(input frame_len_e l);
        case (l)
            LEN16:   return CNT_W'(FRAME16);
            LEN17:   return CNT_W'(FRAME17);
            LEN20:   return CNT_W'(FRAME20);
            default: return CNT_W'(FRAME21);
        endcase
    endfunction : len_bits

    // Left-aligned so the first bit is always the top one
    function automatic logic [FRAME21-1:0] build(input frame_len_e l, input logic w,
                                                 input logic [5:0] a, input logic [7:0] d);
        logic [15:0] c;
        c = {1'b0, w, a, d};
        if (l == LEN20 || l == LEN21) begin
            return {c, crc4(c), 1'b0};
        end
        return {c, 5'h00};
    endfunction : build

    host_e              state_q;
    logic [7:0]         div_q;
    logic [CNT_W-1:0]   nbits_q;
    logic [CNT_W-1:0]   bit_q;
    logic [FRAME21-1:0] tx_q;
    logic [FRAME21-1:0] rx_q;
    logic               init_q;
    logic               sclk_q;
    logic               cs_n_q;
    logic [2:0]         m_s_q;
    logic               m_f_q;
    logic               last_div;

    assign last_div  = div_q == 8'h00;
    assign req_ready = (state_q == H_IDLE);

    // Miso is launched by the device after our falling edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            m_s_q <= 3'h0;
            m_f_q <= 1'b0;
        end else begin
            m_s_q <= {m_s_q[1:0], link.miso};
            if (m_s_q[1] == m_s_q[2]) begin
                m_f_q <= m_s_q[2];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= H_INIT;
            div_q   <= '0;
            nbits_q <= '0;
            bit_q   <= '0;
            tx_q    <= '0;
            rx_q    <= '0;
            init_q  <= 1'b0;
            sclk_q  <= 1'b1;
            cs_n_q  <= 1'b1;
        end else begin
            case (state_q)
                H_INIT: begin
                    // Clear flags left by power-on before any user frame
                    tx_q    <= build(LEN21, 1'b1, WARN_ADDR, 8'hff);
                    nbits_q <= CNT_W'(FRAME21);
                    state_q <= H_SETUP;
                    div_q   <= 8'(HALF - 1);
                end
                H_IDLE: begin
                    if (req_valid) begin
                        tx_q    <= build(frame_len_e'(req_len), req_write, req_addr, req_data);
                        nbits_q <= len_bits(frame_len_e'(req_len));
                        state_q <= H_SETUP;
                        div_q   <= 8'(HALF - 1);
                    end
                end
                H_SETUP: begin
                    cs_n_q <= 1'b0;
                    bit_q  <= '0;
                    div_q  <= div_q - 8'h01;
                    if (last_div) begin
                        sclk_q  <= 1'b0;
                        state_q <= H_LOW;
                        div_q   <= 8'(HALF - 1);
                    end
                end
                H_LOW: begin
                    div_q <= div_q - 8'h01;
                    if (last_div) begin
                        // Mosi moves on the rise, clear of the device's sampling fall
                        tx_q    <= {tx_q[FRAME21-2:0], 1'b0};
                        sclk_q  <= 1'b1;
                        state_q <= H_HIGH;
                        div_q   <= 8'(HALF - 1);
                    end
                end
                H_HIGH: begin
                    div_q <= div_q - 8'h01;
                    if (last_div) begin
                        rx_q  <= {rx_q[FRAME21-2:0], m_f_q};
                        bit_q <= bit_q + 1'b1;
                        div_q <= 8'(HALF - 1);
                        if (bit_q == nbits_q - 1'b1) begin
                            cs_n_q  <= 1'b1;
                            state_q <= H_GAP;
                            div_q   <= 8'(GAP - 1);
                        end else begin
                            sclk_q  <= 1'b0;
                            state_q <= H_LOW;
                        end
                    end
                end
                H_GAP: begin
                    div_q <= div_q - 8'h01;
                    if (last_div) begin
                        init_q  <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    // Clock idles high outside frames, so a private line sees no strays
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = tx_q[FRAME21-1];

    logic [15:0] rx_word;
    logic [3:0]  rx_crc;
    assign rx_word = 16'(rx_q >> (nbits_q - CNT_W'(FRAME16)));
    // Last bit of a 21-bit answer repeats the CRC top bit and is dropped
    assign rx_crc  = 4'(rx_q >> (nbits_q - CNT_W'(FRAME20)));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resp_valid  <= 1'b0;
            resp_data   <= '0;
            resp_crc_ok <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            if (state_q == H_GAP && last_div && init_q) begin
                resp_valid  <= 1'b1;
                resp_data   <= rx_word;
                resp_crc_ok <= (nbits_q < CNT_W'(FRAME20)) || (rx_crc == crc4(rx_word));
            end
        end
    end

    assign init_done = init_q;

endmodule : spi_frame_host

/* test/spi_link_sva.sv */
// Protocol checker for the host-driven serial link
`timescale 1ns/1ps
module spi_link_sva #(
    parameter int HALF = 4
) (
    // System clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    logic       sclk_q;
    logic       cs_q;
    logic [4:0] n_fall_q;
    logic       last_bit_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Falls counted per frame; the last sampled bit kept for the tail check
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_q     <= 1'b1;
            cs_q       <= 1'b1;
            n_fall_q   <= 5'h00;
            last_bit_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            cs_q   <= cs_n;
            if (!cs_n && cs_q) begin
                n_fall_q <= 5'h00;
            end else if (!cs_n && sclk_q && !sclk) begin
                n_fall_q   <= n_fall_q + 5'h01;
                last_bit_q <= mosi;
            end
        end
    end

    property p_oe_cs; miso_oe == !cs_n; endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("miso enable off select");
    property p_miso_still; n_fall_q != 5'h00 && !cs_n && sclk && $past(sclk) |-> $stable(miso_o); endproperty
    a_miso_still: assert property (p_miso_still) else $error("miso moved in high");
    property p_idle_high; cs_n |-> sclk; endproperty
    a_idle_high: assert property (p_idle_high) else $error("clock low outside frame");
    property p_half; $fell(sclk) |-> ##HALF $rose(sclk); endproperty
    a_half: assert property (p_half) else $error("clock low phase wrong");
    property p_count; $rose(cs_n) |-> n_fall_q inside {5'd16, 5'd17, 5'd20, 5'd21}; endproperty
    a_count: assert property (p_count) else $error("bad pulse count");
    property p_sync; $fell(cs_n) |-> !mosi; endproperty
    a_sync: assert property (p_sync) else $error("sync bit not zero");
    property p_tail; $rose(cs_n) && n_fall_q == 5'd21 |-> !last_bit_q; endproperty
    a_tail: assert property (p_tail) else $error("tail bit not zero");
    property p_gap; $rose(cs_n) |-> cs_n [*8] ##1 cs_n [*4]; endproperty
    a_gap: assert property (p_gap) else $error("select gap too short");
endmodule : spi_link_sva

/* test/spi_frame_length_checker_tb_top.sv */
// Bench: host and device pair plus a bench-driven second device
`timescale 1ns/1ps
module spi_frame_length_checker_tb_top
    import spi_flc_pkg::*;
;
    localparam logic [15:0] CLR = {2'b01, WARN_ADDR, 8'h00};
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [5:0]  req_addr = 6'h00;
    logic [7:0]  req_data = 8'h00;
    logic [1:0]  req_len = 2'h3;
    logic        nv_we = 1'b0;
    logic [7:0]  nv_addr = 8'h00;
    logic [7:0]  nv_wdata = 8'h00;
    logic        crc_en = 1'b1;
    logic        req_ready, resp_valid, resp_crc_ok, init_done, wr_pulse;
    logic [15:0] resp_data;
    logic [5:0]  wr_addr, wa;
    logic [7:0]  wr_data, wd;
    logic        fe_a, ce_a, s17_a, fe_b, ce_b, s17_b, started = 1'b0;
    logic [16:0] rq[$];
    logic [13:0] wq[$];
    logic [16:0] e_r;
    logic [13:0] w_r;
    int          seed = 34735;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;

    spi_link_if link_a ();
    spi_link_if link_b ();
    spi_frame_host #(.HALF(4), .GAP(16)) u_spi_frame_host (.clock(clock), .rst(rst),
        .link(link_a), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .req_len(req_len), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_crc_ok(resp_crc_ok), .init_done(init_done));
    spi_frame_dev u_spi_frame_dev (.clock(clock), .rst(rst), .link(link_a), .nv_we(nv_we),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .crc_check_en(crc_en), .frame_error_flag(fe_a),
        .crc_error_flag(ce_a), .seventeen_clock_select(s17_a), .wr_pulse(wr_pulse),
        .wr_addr(wr_addr), .wr_data(wr_data));
    spi_frame_dev u_spi_frame_dev_b (.clock(clock), .rst(rst), .link(link_b), .nv_we(nv_we),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .crc_check_en(crc_en), .frame_error_flag(fe_b),
        .crc_error_flag(ce_b), .seventeen_clock_select(s17_b), .wr_pulse(), .wr_addr(),
        .wr_data());
    spi_link_sva #(.HALF(4)) u_spi_link_sva (.clock(clock), .rst(rst), .sclk(link_a.sclk),
        .cs_n(link_a.cs_n), .mosi(link_a.mosi), .miso_o(link_a.miso_o),
        .miso_oe(link_a.miso_oe), .miso(link_a.miso));

    always #25 clock = ~clock;

    task close_out;
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task host_req(input logic w, input logic [5:0] a, input logic [7:0] d,
                  input logic [1:0] l, input logic [16:0] e);
        rq.push_back(e);
        if (w) wq.push_back({a, d});
        @(posedge clock);
        #2;
        started = 1'b1;
        req_write = w;
        req_addr = a;
        req_data = d;
        req_len = l;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            @(posedge clock);
            #2;
        end
        @(posedge clock);
        #2;
        req_valid = 1'b0;
    endtask : host_req

    function automatic logic [20:0] vec(input logic [15:0] c);
        logic [3:0] r;
        r = CRC_SEED;
        for (int i = 15; i >= 0; i--) r = {r[2:0], 1'b0} ^ ((r[3] ^ c[i]) ? CRC_POLY : 4'h0);
        return {c, r, 1'b0};
    endfunction : vec

    // Released data line flips so a stale level never passes for data
    task b_frame(input logic [20:0] v, input int n);
        link_b.cs_n = 1'b0;
        link_b.mosi = v[20];
        #80;
        for (int i = 1; i <= n; i++) begin
            link_b.sclk = 1'b0;
            #80;
            link_b.sclk = 1'b1;
            if (i < n) link_b.mosi = v[20-i];
            #80;
        end
        link_b.cs_n = 1'b1;
        link_b.mosi = ~link_b.mosi;
        #1000;
    endtask : b_frame

    // Strays run after a b_frame land well past the guard, so only the count is disturbed
    task b_stray(input int k);
        repeat (k) begin
            link_b.sclk = 1'b0;
            link_b.mosi = ~link_b.mosi;
            #80;
            link_b.sclk = 1'b1;
            #80;
        end
        #1000;
    endtask : b_stray

    task b_case(input int n1, input int ns, input int n2, input logic e);
        b_frame(vec(CLR), 21);
        check(fe_b, 1'b0);
        b_frame(vec(16'h0000), n1);
        b_stray(ns);
        b_frame(vec(16'h0000), n2);
        check(fe_b, e);
        b_frame(vec(16'h0000), n2);
        check(fe_b, e);
    endtask : b_case

    always @(posedge clock) begin
        if (started && resp_valid === 1'b1) begin
            e_r = rq.size() ? rq.pop_front() : 17'h1ffff;
            if (e_r[16]) check(resp_data, e_r[15:0]);
            check(resp_crc_ok, 1'b1);
        end
        if (started && wr_pulse === 1'b1) begin
            w_r = wq.size() ? wq.pop_front() : 14'h3fff;
            check({wr_addr, wr_data}, w_r);
        end
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        link_b.sclk = 1'b1;
        link_b.cs_n = 1'b1;
        link_b.mosi = 1'b0;
        repeat (5) @(posedge clock);
        #2;
        rst = 1'b0;
        check(s17_b, S17_RESET);
        wait (init_done === 1'b1);
        @(posedge clock);
        #2;
        check(fe_a, 1'b0);
        check(ce_a, 1'b0);
        wa = {1'b0, 5'($random(seed))} | 6'h02;
        wd = 8'($random(seed));
        host_req(1'b1, wa, wd, LEN21, 17'h00000);
        host_req(1'b0, WARN_ADDR, 8'h00, LEN21, 17'h00000);
        host_req(1'b0, NOP_ADDR, 8'h00, LEN20, {1'b1, WARN_FIXED, 12'h000});
        host_req(1'b0, WARN_ADDR, 8'h00, LEN16, 17'h10000);
        host_req(1'b0, NOP_ADDR, 8'h00, LEN21, {1'b1, WARN_FIXED, 12'h000});
        wait (rq.size() == 0);
        b_stray(2);
        b_frame(vec(16'h0000), 21);
        check(fe_b, 1'b1);
        check(ce_b, 1'b1);
        b_case(16, 1, 16, 1'b1);
        b_case(21, 3, 21, 1'b0);
        b_frame(vec(CLR), 21);
        b_frame(vec(16'h8000), 21);
        check(fe_b, 1'b1);
        // Stray 20 ns after select rises lands in the guard, so the clear is dropped
        fork
            b_frame(vec(CLR), 16);
            begin
                #2660;
                b_stray(1);
            end
        join
        check(fe_b, 1'b1);
        b_frame(vec(CLR), 21);
        check(fe_b, 1'b1);
        @(posedge clock);
        #2;
        nv_addr = NV_S17_LOC;
        nv_wdata = 8'($random(seed)) | 8'h02;
        nv_we = 1'b1;
        @(posedge clock);
        #2;
        nv_we = 1'b0;
        @(posedge clock);
        #2;
        check(s17_b, 1'b1);
        check(s17_a, 1'b1);
        b_case(17, 1, 17, 1'b1);
        b_case(16, 2, 16, 1'b1);
        check(16'(wq.size()), 16'h0000);
        close_out();
    end
endmodule : spi_frame_length_checker_tb_top
